/* hw/bmsd_pkg.sv */
// shared constants and types for the boot mode select and decode block
package bmsd_pkg;

  // boot select field
  localparam int BMSD_SEL_W = 4;
  localparam int BMSD_LPB_BIT = 3;
  localparam int BMSD_SRC_W = 3;

  // low three bits of the boot select code
  localparam logic [2:0] BMSD_SRC_FUSE = 3'h0;
  localparam logic [2:0] BMSD_SRC_USB = 3'h1;
  localparam logic [2:0] BMSD_SRC_EMMC1 = 3'h2;
  localparam logic [2:0] BMSD_SRC_SD2 = 3'h3;
  localparam logic [2:0] BMSD_SRC_NOR = 3'h4;
  localparam logic [2:0] BMSD_SRC_NAND = 3'h5;
  localparam logic [2:0] BMSD_SRC_RSV6 = 3'h6;
  localparam logic [2:0] BMSD_SRC_RSV7 = 3'h7;

  // full code for low-power 1.8 V eMMC
  localparam logic [3:0] BMSD_CODE_EMMC_1V8 = 4'hA;

  // serial flash data width select
  localparam logic [1:0] BMSD_FW_1BIT = 2'h0;
  localparam logic [1:0] BMSD_FW_4BIT = 2'h1;
  localparam logic [1:0] BMSD_FW_8BIT = 2'h2;

  // boot status register layout
  localparam int BMSD_STAT_W = 8;
  localparam int BMSD_STAT_OVR_BIT = 4;
  localparam int BMSD_STAT_LATCH_BIT = 5;
  localparam int BMSD_STAT_RSV_BIT = 6;
  localparam int BMSD_STAT_LPB_BIT = 7;
  localparam logic [7:0] BMSD_STAT_RST = 8'h00;

  // pin settle time before sampling
  localparam int BMSD_CLK_MHZ = 125;
  localparam int BMSD_SETTLE_NS = 200;
  localparam int BMSD_SETTLE_CYC =
    (BMSD_SETTLE_NS * BMSD_CLK_MHZ + 999) / 1000;
  localparam int BMSD_CNT_W = 8;

  // recovery serial port instances
  localparam int BMSD_SPI_N = 4;
  localparam logic [1:0] BMSD_SPI_LAST = 2'h3;

  // pad groups and alternate function codes
  localparam int BMSD_NGRP = 8;
  localparam int BMSD_ALT_W = 3;
  localparam logic [2:0] BMSD_ALT0 = 3'h0;
  localparam logic [2:0] BMSD_ALT1 = 3'h1;
  localparam logic [2:0] BMSD_ALT2 = 3'h2;
  localparam logic [2:0] BMSD_ALT5 = 3'h5;

  // boot interface routed to the pads
  typedef enum logic [3:0] {
    BMSD_IF_NONE = 4'h0,
    BMSD_IF_FLASH = 4'h1,
    BMSD_IF_SDH1 = 4'h2,
    BMSD_IF_SDH2 = 4'h3,
    BMSD_IF_SPI1 = 4'h4,
    BMSD_IF_SPI2 = 4'h5,
    BMSD_IF_SPI3 = 4'h6,
    BMSD_IF_SPI4 = 4'h7,
    BMSD_IF_USB = 4'h8
  } bmsd_if_t;

  // boot sequence states, gray along the usual path
  typedef enum logic [2:0] {
    BMSD_ST_IDLE = 3'b000,
    BMSD_ST_SETTLE = 3'b001,
    BMSD_ST_PRIMARY = 3'b011,
    BMSD_ST_RECOVERY = 3'b010,
    BMSD_ST_SERIAL = 3'b110,
    BMSD_ST_DONE = 3'b111
  } bmsd_state_t;

endpackage : bmsd_pkg

/* hw/bmsd_pad_mux.sv */
// pad multiplexer settings for the selected boot interface
`timescale 1ns/1ns
module bmsd_pad_mux
  import bmsd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire bmsd_if_t iface_in,
  input wire logic [1:0] flash_width_in,
  output logic [BMSD_NGRP*BMSD_ALT_W-1:0] pad_alt_out,
  output logic [BMSD_NGRP-1:0] pad_en_out
);

  // group 0 serial flash data0-3/cs/clk pads
  // group 1 strobe and data4-7 pads shared by flash and host 1
  // group 2 host 1 cmd/clk/data0-3, group 3 host 2 pads
  // groups 4..7 serial port instances 1..4
  function automatic logic [BMSD_ALT_W:0] grp_cfg(
    input int g,
    input bmsd_if_t ifc,
    input logic [1:0] fw
  );
    logic [BMSD_ALT_W:0] r;
    r = {1'b0, BMSD_ALT0};
    case (g)
      0: if (ifc == BMSD_IF_FLASH) r = {1'b1, BMSD_ALT1};
      1:
      begin
        if (ifc == BMSD_IF_FLASH && fw == BMSD_FW_8BIT)
          r = {1'b1, BMSD_ALT1};
        else if (ifc == BMSD_IF_SDH1)
          r = {1'b1, BMSD_ALT0};
      end
      2: if (ifc == BMSD_IF_SDH1) r = {1'b1, BMSD_ALT0};
      3: if (ifc == BMSD_IF_SDH2) r = {1'b1, BMSD_ALT0};
      4: if (ifc == BMSD_IF_SPI1) r = {1'b1, BMSD_ALT2};
      5: if (ifc == BMSD_IF_SPI2) r = {1'b1, BMSD_ALT2};
      6: if (ifc == BMSD_IF_SPI3) r = {1'b1, BMSD_ALT1};
      7: if (ifc == BMSD_IF_SPI4) r = {1'b1, BMSD_ALT5};
      default: r = {1'b0, BMSD_ALT0};
    endcase
    return r;
  endfunction : grp_cfg

  // one registered setting per pad group
  genvar gi;
  generate
    for (gi = 0; gi < BMSD_NGRP; gi = gi + 1)
    begin : g_grp
      logic [BMSD_ALT_W:0] cfg_nxt;
      logic [BMSD_ALT_W:0] cfg_r;
      // [RULE17] per-group alternate select
      assign cfg_nxt = grp_cfg(gi, iface_in, flash_width_in);
      always_ff @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          cfg_r <= '0;
        else
          cfg_r <= cfg_nxt;
      end
      assign pad_alt_out[gi*BMSD_ALT_W +: BMSD_ALT_W] = cfg_r[BMSD_ALT_W-1:0];
      assign pad_en_out[gi] = cfg_r[BMSD_ALT_W];
    end
  endgenerate

endmodule : bmsd_pad_mux

/* hw/bmsd_top.sv */
// boot mode sampling, decode, fallback sequencing and core release
// Operation
// [RULE1] boot mode comes from four select pins
// [RULE2] pins sampled before boot code starts
// [RULE3] sampled value latched, later pin changes ignored
// [RULE4] x000 selects boot from internal fuses
// [RULE5] low codes pick USB, eMMC, SD, NOR, NAND
// [RULE6] bit 3 set selects low-power boot type
// [RULE7] board never straps reserved codes
// [RULE8] fuse override may replace pin boot mode
// [RULE9] normal type: application cores load, rt waits
// [RULE10] low-power: only rt core, cannot start apps
// [RULE11] primary device from config in normal/fuse mode
// [RULE12] on failure recover from serial ports 1-4
// [RULE13] serial download over USB port one
// [RULE14] serial NOR supports 1, 4, 8 bits
// [RULE15] serial NAND supports 1, 4, 8 bits
// [RULE16] SD/eMMC from host one or two
// [RULE17] pad mux set for chosen boot interface
// [RULE18] USB port uses dedicated pins, no muxing
// [RULE19] board keeps select pins free of conflicts
`timescale 1ns/1ns
module bmsd_top
  import bmsd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [BMSD_SEL_W-1:0] boot_sel_pins_in,
  input wire logic fuse_override_en_in,
  input wire logic [BMSD_SEL_W-1:0] fuse_boot_mode_in,
  input wire logic [BMSD_SRC_W-1:0] fuse_primary_dev_in,
  input wire logic fuse_sd_host2_in,
  input wire logic [1:0] fuse_flash_width_in,
  input wire logic boot_ok_in,
  input wire logic boot_fail_in,
  input wire logic rt_fw_ready_in,
  input wire logic app_start_req_in,
  output logic [BMSD_STAT_W-1:0] boot_config_status_register_out,
  output logic rom_start_out,
  output logic low_power_boot_type_out,
  output logic app_core_run_out,
  output logic rt_core_run_out,
  output bmsd_if_t boot_iface_out,
  output logic [1:0] flash_width_out,
  output logic emmc_1v8_out,
  output logic usb_dl_active_out,
  output logic boot_done_out,
  output logic [BMSD_NGRP*BMSD_ALT_W-1:0] pad_alt_out,
  output logic [BMSD_NGRP-1:0] pad_en_out
);

  logic [BMSD_SEL_W-1:0] pin_meta_r;
  logic [BMSD_SEL_W-1:0] pin_sync_r;
  bmsd_state_t state_r;
  bmsd_state_t state_nxt;
  logic [BMSD_CNT_W-1:0] settle_cnt_r;
  logic settle_done;
  logic latched_r;
  logic [BMSD_SEL_W-1:0] mode_r;
  logic ovr_r;
  logic [BMSD_SEL_W-1:0] mode_nxt;
  logic [BMSD_SRC_W-1:0] src;
  logic [BMSD_SRC_W-1:0] prim_src;
  logic rsv;
  logic low_power_boot_type;
  logic [1:0] spi_idx_r;
  bmsd_if_t iface_nxt;
  bmsd_if_t iface_r;
  logic rt_fw_ready_r;
  logic [1:0] fw_r;
  logic emmc_1v8_r;

  // select pins come from the board, two flops before use
  // [RULE1] four-pin boot select field
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= boot_sel_pins_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // settle counter lets straps reach level after reset release
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      settle_cnt_r <= '0;
    else if (state_r == BMSD_ST_SETTLE && !settle_done)
      settle_cnt_r <= settle_cnt_r + 8'h01;
  end
  assign settle_done = (settle_cnt_r == BMSD_CNT_W'(BMSD_SETTLE_CYC - 1));

  // pick pin or fuse source for the boot mode
  // [RULE8] fuse override takes precedence
  assign mode_nxt = fuse_override_en_in ? fuse_boot_mode_in : pin_sync_r;

  // capture once at end of settle, never again until reset
  // [RULE2] sample before boot code release
  // [RULE3] latch and hold sampled mode
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_r <= '0;
      ovr_r <= 1'b0;
      latched_r <= 1'b0;
    end
    else if (state_r == BMSD_ST_SETTLE && settle_done && !latched_r)
    begin
      mode_r <= mode_nxt;
      ovr_r <= fuse_override_en_in;
      latched_r <= 1'b1;
    end
  end

  // decode of the latched code
  // [RULE6] bit 3 is the low-power boot type
  assign low_power_boot_type = mode_r[BMSD_LPB_BIT];
  assign src = mode_r[BMSD_SRC_W-1:0];
  // [RULE7] reserved codes flagged, handled as serial download
  assign rsv = (src == BMSD_SRC_RSV6) || (src == BMSD_SRC_RSV7);

  // [RULE4] internal fuse mode takes device from fuse config
  // [RULE11] primary device from boot configuration
  always_comb
  begin
    prim_src = src;
    if (src == BMSD_SRC_FUSE)
      prim_src = fuse_primary_dev_in;
  end

  // boot sequence
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      BMSD_ST_IDLE:
        state_nxt = BMSD_ST_SETTLE;
      BMSD_ST_SETTLE:
        if (latched_r)
        begin
          // [RULE13] usb download or reserved code
          if (rsv || prim_src == BMSD_SRC_USB)
            state_nxt = BMSD_ST_SERIAL;
          else
            state_nxt = BMSD_ST_PRIMARY;
        end
      BMSD_ST_PRIMARY:
        if (boot_ok_in)
          state_nxt = BMSD_ST_DONE;
        // [RULE12] primary failed, go to recovery
        else if (boot_fail_in)
          state_nxt = BMSD_ST_RECOVERY;
      BMSD_ST_RECOVERY:
        if (boot_ok_in)
          state_nxt = BMSD_ST_DONE;
        else if (boot_fail_in && spi_idx_r == BMSD_SPI_LAST)
          state_nxt = BMSD_ST_SERIAL;
      BMSD_ST_SERIAL:
        if (boot_ok_in)
          state_nxt = BMSD_ST_DONE;
      BMSD_ST_DONE:
        state_nxt = BMSD_ST_DONE;
      default:
        state_nxt = BMSD_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_r <= BMSD_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // recovery walks serial ports one to four in order
  // [RULE12] only serial port instances 1-4
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      spi_idx_r <= '0;
    else if (state_r == BMSD_ST_RECOVERY && boot_fail_in &&
             spi_idx_r != BMSD_SPI_LAST)
      spi_idx_r <= spi_idx_r + 2'h1;
  end

  // interface to route onto the pads
  always_comb
  begin
    iface_nxt = BMSD_IF_NONE;
    case (state_r)
      BMSD_ST_PRIMARY:
        // [RULE5] code picks the primary device
        case (prim_src)
          // [RULE16] host instance one or two
          BMSD_SRC_EMMC1, BMSD_SRC_SD2:
            if (src == BMSD_SRC_FUSE)
              iface_nxt = fuse_sd_host2_in ? BMSD_IF_SDH2 : BMSD_IF_SDH1;
            else if (src == BMSD_SRC_EMMC1)
              iface_nxt = BMSD_IF_SDH1;
            else
              iface_nxt = BMSD_IF_SDH2;
          BMSD_SRC_NOR, BMSD_SRC_NAND:
            iface_nxt = BMSD_IF_FLASH;
          default:
            iface_nxt = BMSD_IF_NONE;
        endcase
      BMSD_ST_RECOVERY:
        iface_nxt = bmsd_if_t'(4'(BMSD_IF_SPI1) + {2'h0, spi_idx_r});
      // [RULE18] dedicated usb pins, no pad groups enabled
      BMSD_ST_SERIAL:
        iface_nxt = BMSD_IF_USB;
      default:
        iface_nxt = BMSD_IF_NONE;
    endcase
  end

  // registered interface and flash width
  // [RULE14] nor width 1/4/8 from fuse
  // [RULE15] nand width 1/4/8 from fuse
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      iface_r <= BMSD_IF_NONE;
      fw_r <= BMSD_FW_1BIT;
    end
    else
    begin
      iface_r <= iface_nxt;
      if (fuse_flash_width_in == BMSD_FW_4BIT ||
          fuse_flash_width_in == BMSD_FW_8BIT)
        fw_r <= fuse_flash_width_in;
      else
        fw_r <= BMSD_FW_1BIT;
    end
  end

  // 1.8 V eMMC signalling for the low-power eMMC code
  // [RULE6] code 1010 selects 1.8 V eMMC
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      emmc_1v8_r <= 1'b0;
    else
      emmc_1v8_r <= latched_r && (mode_r == BMSD_CODE_EMMC_1V8);
  end

  // rt core firmware ready is sticky; reset wins over set
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rt_fw_ready_r <= 1'b0;
    else if (rt_fw_ready_in)
      rt_fw_ready_r <= 1'b1;
  end

  // core release
  // [RULE9] apps load in normal type, rt waits for firmware
  // [RULE10] low-power: rt only, start requests ignored
  assign app_core_run_out = latched_r && !low_power_boot_type;
  assign rt_core_run_out = latched_r && (low_power_boot_type || rt_fw_ready_r);
  assign rom_start_out = latched_r;
  assign low_power_boot_type_out = latched_r && low_power_boot_type;

  // status register view of the latched configuration
  always_comb
  begin
    boot_config_status_register_out = BMSD_STAT_RST;
    boot_config_status_register_out[BMSD_SEL_W-1:0] = mode_r;
    boot_config_status_register_out[BMSD_STAT_OVR_BIT] = ovr_r;
    boot_config_status_register_out[BMSD_STAT_LATCH_BIT] = latched_r;
    boot_config_status_register_out[BMSD_STAT_RSV_BIT] = latched_r && rsv;
    boot_config_status_register_out[BMSD_STAT_LPB_BIT] = latched_r && low_power_boot_type;
  end

  assign boot_iface_out = iface_r;
  assign flash_width_out = fw_r;
  assign emmc_1v8_out = emmc_1v8_r;
  assign usb_dl_active_out = (state_r == BMSD_ST_SERIAL);
  assign boot_done_out = (state_r == BMSD_ST_DONE);

  // pad multiplexer programming
  // [RULE17] route chosen interface to its pads
  bmsd_pad_mux u_pad_mux (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .iface_in(iface_nxt),
    .flash_width_in(fw_r),
    .pad_alt_out(pad_alt_out),
    .pad_en_out(pad_en_out)
  );

endmodule : bmsd_top

/* sim/bmsd_checker.sv */
// concurrent checks on the boot select block ports
`timescale 1ns/1ns
module bmsd_checker
  import bmsd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic boot_ok_in,
  input wire logic boot_fail_in,
  input wire logic [BMSD_STAT_W-1:0] boot_config_status_register_out,
  input wire logic rom_start_out,
  input wire logic low_power_boot_type_out,
  input wire logic app_core_run_out,
  input wire logic rt_core_run_out,
  input wire bmsd_if_t boot_iface_out,
  input wire logic [BMSD_NGRP*BMSD_ALT_W-1:0] pad_alt_out,
  input wire logic [BMSD_NGRP-1:0] pad_en_out
);
  // one clock domain, reset aborts every check
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  stat_hold_a: assert property (
    rom_start_out |=> $stable(boot_config_status_register_out))
    else $error("status changed after latch");
  rom_stays_a: assert property (
    $rose(rom_start_out) |=> rom_start_out [*8])
    else $error("rom start dropped");
  pre_latch_a: assert property (
    !rom_start_out |->
    boot_iface_out == BMSD_IF_NONE && pad_en_out == 8'h00)
    else $error("interface before sampling");
  lpb_map_a: assert property (
    rom_start_out |->
    low_power_boot_type_out == boot_config_status_register_out[3])
    else $error("boot type wrong");
  app_run_a: assert property (
    rom_start_out |->
    app_core_run_out == !boot_config_status_register_out[3])
    else $error("app core run wrong");
  lp_no_app_a: assert property (
    low_power_boot_type_out |-> !app_core_run_out && rt_core_run_out)
    else $error("low power core state wrong");
  fail_spi_a: assert property (
    boot_iface_out == BMSD_IF_SPI1 && boot_fail_in && !boot_ok_in |->
    ##2 boot_iface_out == BMSD_IF_SPI2)
    else $error("no step to port two");
  usb_nopad_a: assert property (
    boot_iface_out == BMSD_IF_USB |-> pad_en_out == 8'h00)
    else $error("pads set for usb");
  spi1_pad_a: assert property (
    boot_iface_out == BMSD_IF_SPI1 |->
    pad_en_out[4] && pad_alt_out[14:12] == BMSD_ALT2)
    else $error("port one pads wrong");
endmodule : bmsd_checker

bind bmsd_top bmsd_checker u_bmsd_checker (.mclk_in, .rst_b_in,
  .boot_ok_in, .boot_fail_in, .boot_config_status_register_out,
  .rom_start_out, .low_power_boot_type_out, .app_core_run_out,
  .rt_core_run_out, .boot_iface_out, .pad_alt_out, .pad_en_out);

/* sim/bmsd_board_model.sv */
// board straps and attached boot memories answering each boot attempt
`timescale 1ns/1ns
module bmsd_board_model
  import bmsd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rom_start_in,
  input wire bmsd_if_t iface_in,
  input wire logic [3:0] strap_in,
  input wire logic [2:0] fails_in,
  input wire logic [3:0] lat_in,
  output logic [3:0] pins_out,
  output logic ok_out,
  output logic fail_out
);
  bmsd_if_t seen;
  int wait_c = 0;
  int fail_c = 0;

  // straps steady until sampled, then the pins carry other traffic
  // straps held until rom start, then inverted every cycle
  always_ff @(posedge mclk_in)
    pins_out <= rom_start_in ? ~pins_out : strap_in;

  // memory answers after lat_in cycles, failing fails_in times first
  always_ff @(posedge mclk_in)
  begin
    ok_out <= 1'b0;
    fail_out <= 1'b0;
    seen <= iface_in;
    if (!rom_start_in)
      fail_c <= 0;
    if (iface_in != seen)
      wait_c <= lat_in;
    else if (wait_c > 0)
      wait_c <= wait_c - 1;
    if (wait_c == 1 && iface_in != BMSD_IF_NONE && iface_in != BMSD_IF_USB)
    begin
      fail_out <= fail_c < fails_in;
      ok_out <= fail_c >= fails_in;
      fail_c <= fail_c + 1;
    end
  end
endmodule : bmsd_board_model

/* sim/bmsd_top_bench.sv */
// self-checking bench for boot mode select and decode
`timescale 1ns/1ns
module bmsd_top_bench;
  import bmsd_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ovr = 1'b0;
  logic [3:0] fmode = 4'h0;
  logic [2:0] fdev = BMSD_SRC_NOR;
  logic fh2 = 1'b1;
  logic [1:0] fw = 2'h0;
  logic rtr = 1'b0;
  logic appq = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [2:0] fails = 3'h0;
  logic [3:0] lat = 4'h4;
  logic [3:0] pins;
  logic ok, fail, rom, low_power_boot_type, app, rt, e18, usb, done;
  logic [7:0] stat, pen;
  logic [23:0] palt;
  logic [1:0] fwo;
  bmsd_if_t ifc;
  int error_cnt = 0;
  int checks = 0;
  int n;

  bmsd_top u_bmsd_top (.mclk_in(mclk), .rst_b_in(rst_b),
    .boot_sel_pins_in(pins), .fuse_override_en_in(ovr),
    .fuse_boot_mode_in(fmode), .fuse_primary_dev_in(fdev),
    .fuse_sd_host2_in(fh2), .fuse_flash_width_in(fw), .boot_ok_in(ok),
    .boot_fail_in(fail), .rt_fw_ready_in(rtr), .app_start_req_in(appq),
    .boot_config_status_register_out(stat), .rom_start_out(rom),
    .low_power_boot_type_out(low_power_boot_type), .app_core_run_out(app),
    .rt_core_run_out(rt), .boot_iface_out(ifc), .flash_width_out(fwo),
    .emmc_1v8_out(e18), .usb_dl_active_out(usb), .boot_done_out(done),
    .pad_alt_out(palt), .pad_en_out(pen));

  bmsd_board_model u_bmsd_board_model (.mclk_in(mclk), .rom_start_in(rom),
    .iface_in(ifc), .strap_in(strap), .fails_in(fails), .lat_in(lat),
    .pins_out(pins), .ok_out(ok), .fail_out(fail));

  // 125 MHz clock
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  task complete_run;
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [23:0] seen,
    input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : step

  // reset for 8 cycles, strap a code, wait for sampling
  task automatic boot(input logic [3:0] code, input logic [2:0] nf);
    strap = code;
    fails = nf;
    rst_b = 1'b0;
    step(8);
    rst_b = 1'b1;
    n = 0;
    while (rom !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
    chk("rom_start", rom, 1'b1);
    step(3);
  endtask : boot

  function automatic bmsd_if_t exp_if(input logic [3:0] c);
    case (c[2:0])
      3'h2: return BMSD_IF_SDH1;
      3'h3: return BMSD_IF_SDH2;
      3'h0, 3'h4, 3'h5: return BMSD_IF_FLASH;
      default: return BMSD_IF_USB;
    endcase
  endfunction : exp_if

  // every code: status, type, interface, then pins toggle
  // reserved straps get the same checks, with the flag set
  task automatic t_codes;
    logic rsv;
    for (int c = 0; c < 16; c++)
    begin
      boot(c[3:0], 3'h0);
      rsv = c[2:1] == 2'b11;
      chk("status", stat, {c[3], rsv, 2'b10, c[3:0]});
      chk("lpb", low_power_boot_type, c[3]);
      chk("app_run", app, !c[3]);
      chk("iface", ifc, exp_if(c[3:0]));
      chk("emmc_1v8", e18, c == 10);
      chk("usb_dl", usb, exp_if(c[3:0]) == BMSD_IF_USB);
      step(12);
      chk("status_held", stat[3:0], c[3:0]);
      chk("done", done, exp_if(c[3:0]) != BMSD_IF_USB);
    end
  endtask : t_codes

  // primary fails, then ports one to four, then usb download
  task automatic t_fallback;
    bmsd_if_t prev;
    logic [2:0] alts [4] = '{BMSD_ALT2, BMSD_ALT2, BMSD_ALT1, BMSD_ALT5};
    lat = 4'h1;
    boot(4'h2, 3'h5);
    chk("iface", ifc, BMSD_IF_SDH1);
    chk("sdh1_pad", pen[2], 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      prev = ifc;
      n = 0;
      while (ifc === prev && n < 20)
      begin
        step(1);
        n++;
      end
      chk("iface", ifc, k < 4 ? bmsd_if_t'(4 + k) : BMSD_IF_USB);
      chk("pad_en", pen, k < 4 ? 8'h10 << k : 8'h00);
      if (k < 4)
        chk("pad_alt", palt[3*(4+k)+:3], alts[k]);
    end
    lat = 4'h4;
  endtask : t_fallback

  // fuse override replaces the pin code
  task automatic t_override;
    ovr = 1'b1;
    fmode = 4'h3;
    boot(4'h1, 3'h0);
    chk("status", stat, 8'h33);
    chk("iface", ifc, BMSD_IF_SDH2);
    chk("sdh2_pad", palt[11:9], BMSD_ALT0);
    chk("sdh2_en", pen, 8'h08);
    ovr = 1'b0;
  endtask : t_override

  // flash widths for NOR and NAND
  task automatic t_widths;
    for (int i = 0; i < 6; i++)
    begin
      fw = 2'(i % 3);
      boot(i < 3 ? 4'h4 : 4'h5, 3'h0);
      chk("width", fwo, fw);
      chk("hi_data_pad", pen[1], fw == BMSD_FW_8BIT);
      chk("flash_alt", palt[2:0], BMSD_ALT1);
      chk("flash_en", pen[0], 1'b1);
    end
  endtask : t_widths

  // core release in both boot types
  task automatic t_cores;
    boot(4'hC, 3'h0);
    appq = 1'b1;
    step(4);
    chk("lp_app", app, 1'b0);
    chk("lp_rt", rt, 1'b1);
    appq = 1'b0;
    boot(4'h2, 3'h0);
    chk("rt_wait", rt, 1'b0);
    rtr = 1'b1;
    step(4);
    chk("rt_run", rt, 1'b1);
    rtr = 1'b0;
  endtask : t_cores

  initial
  begin
    t_codes();
    t_fallback();
    t_override();
    t_widths();
    t_cores();
    complete_run();
  end

  // cut a hang short
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : bmsd_top_bench
